/* File: pkg/cabo_pkg.sv */
// Package for the core add and bit-operation execution block
package cabo_pkg;
  // Instruction word layout (14-bit)
  localparam int INSN_W = 14;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int DEST_POS = 7;
  localparam int BIT_LO = 7;
  localparam int DIGIT_POS = 4;
  // Status bit positions inside the status word
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [2:0] STATUS_RST = 3'h0;
  // Opcode patterns (top six bits for byte ops, top five for add literal, top four for bit ops)
  localparam logic [5:0] OP_ADD_FILE = 6'h07;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [3:0] OP_BIT_CLR = 4'h4;
  localparam logic [3:0] OP_BIT_SET = 4'h5;
  localparam logic [3:0] OP_TEST_ZERO = 4'h6;
  localparam logic [3:0] OP_TEST_ONE = 4'h7;
  localparam logic [4:0] OP_ADD_LIT = 5'h1f;
  localparam logic [5:0] OP_AND_LIT = 6'h39;

  // Decoded operation
  typedef enum logic [3:0] {
    CABO_NONE = 4'b0000,
    CABO_ADD_LIT_OP = 4'b0001,
    CABO_ADD_FILE_OP = 4'b0010,
    CABO_AND_LIT_OP = 4'b0011,
    CABO_AND_FILE_OP = 4'b0100,
    CABO_CLR_OP = 4'b0101,
    CABO_SET_OP = 4'b0110,
    CABO_TSZ_OP = 4'b0111,
    CABO_TSO_OP = 4'b1000
  } cabo_op_t;

  // Status flags carried together
  typedef struct packed {
    logic z;
    logic digit_carry_flag;
    logic c;
  } cabo_status_t;

  // Issued instruction
  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] word;
  } cabo_insn_t;
endpackage

/* File: src/cabo_core.sv */
// Execution unit for add, AND, bit clear/set and bit-test-skip instructions
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Function
// - Add literal to work, all three flags
// - Add work and file, all three flags
// - Destination bit: 0 work, 1 file
// - AND literal into work, zero flag only
// - AND work with file, zero flag only
// - Clear selected file bit, flags unchanged
// - Set selected file bit, flags unchanged
// - Skip-if-zero discards next when bit 0
// - Skip-if-one discards next when bit 1
// - Discarded slot runs as no-operation, one cycle
module cabo_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction issue
  input wire cabo_pkg::cabo_insn_t insn,
  // Software view of the file registers
  input wire logic [6:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Core state
  output logic [7:0] work_out,
  output cabo_pkg::cabo_status_t status_out,
  output logic skip_out,
  output logic exec_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Classify an instruction word
  function automatic cabo_pkg::cabo_op_t decode(input logic [13:0] w);
    cabo_pkg::cabo_op_t op;
    op = cabo_pkg::CABO_NONE;
    if (w[13:9] == cabo_pkg::OP_ADD_LIT) begin
      op = cabo_pkg::CABO_ADD_LIT_OP;
    end else if (w[13:8] == cabo_pkg::OP_AND_LIT) begin
      op = cabo_pkg::CABO_AND_LIT_OP;
    end else if (w[13:8] == cabo_pkg::OP_ADD_FILE) begin
      op = cabo_pkg::CABO_ADD_FILE_OP;
    end else if (w[13:8] == cabo_pkg::OP_AND_FILE) begin
      op = cabo_pkg::CABO_AND_FILE_OP;
    end else if (w[13:10] == cabo_pkg::OP_BIT_CLR) begin
      op = cabo_pkg::CABO_CLR_OP;
    end else if (w[13:10] == cabo_pkg::OP_BIT_SET) begin
      op = cabo_pkg::CABO_SET_OP;
    end else if (w[13:10] == cabo_pkg::OP_TEST_ZERO) begin
      op = cabo_pkg::CABO_TSZ_OP;
    end else if (w[13:10] == cabo_pkg::OP_TEST_ONE) begin
      op = cabo_pkg::CABO_TSO_OP;
    end
    return op;
  endfunction

  // Add two bytes; returns {carry, digit carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {full[8], low[cabo_pkg::DIGIT_POS], full[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] file_reg [cabo_pkg::FILE_DEPTH];
  logic [7:0] work_reg;
  cabo_pkg::cabo_status_t status_reg;
  logic skip_reg;
  logic [7:0] rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational execution

  cabo_pkg::cabo_op_t op;
  logic live;
  logic [6:0] faddr;
  logic [2:0] bsel;
  logic dest_file;
  logic [7:0] lit;
  logic [7:0] fval;
  logic [9:0] sum_lit;
  logic [9:0] sum_file;
  logic [7:0] result;
  logic [7:0] work_next;
  cabo_pkg::cabo_status_t status_next;
  logic file_we;
  logic [7:0] file_next;
  logic skip_next;

  // A skipped slot is forced to no-operation whatever was issued
  assign live = insn.valid && !skip_reg;
  assign op = live ? decode(insn.word) : cabo_pkg::CABO_NONE;
  assign faddr = insn.word[cabo_pkg::ADDR_W-1:0];
  assign bsel = insn.word[cabo_pkg::BIT_LO+2:cabo_pkg::BIT_LO];
  assign dest_file = insn.word[cabo_pkg::DEST_POS];
  assign lit = insn.word[7:0];
  assign fval = file_reg[faddr];
  assign sum_lit = add8(work_reg, lit);
  assign sum_file = add8(work_reg, fval);

  // Result, destination and flag selection per operation
  always_comb begin
    result = 8'h00;
    work_next = work_reg;
    status_next = status_reg;
    file_we = 1'b0;
    file_next = fval;
    skip_next = 1'b0;
    unique case (op)
      cabo_pkg::CABO_ADD_LIT_OP: begin
        result = sum_lit[7:0];
        work_next = result;
        status_next.c = sum_lit[9];
        status_next.digit_carry_flag = sum_lit[8];
        status_next.z = (result == 8'h00);
      end
      cabo_pkg::CABO_ADD_FILE_OP: begin
        result = sum_file[7:0];
        status_next.c = sum_file[9];
        status_next.digit_carry_flag = sum_file[8];
        status_next.z = (result == 8'h00);
        if (dest_file) begin
          file_we = 1'b1;
          file_next = result;
        end else begin
          work_next = result;
        end
      end
      cabo_pkg::CABO_AND_LIT_OP: begin
        result = work_reg & lit;
        work_next = result;
        status_next.z = (result == 8'h00);
      end
      cabo_pkg::CABO_AND_FILE_OP: begin
        result = work_reg & fval;
        status_next.z = (result == 8'h00);
        if (dest_file) begin
          file_we = 1'b1;
          file_next = result;
        end else begin
          work_next = result;
        end
      end
      cabo_pkg::CABO_CLR_OP: begin
        file_we = 1'b1;
        file_next = fval & ~(8'h01 << bsel);
      end
      cabo_pkg::CABO_SET_OP: begin
        file_we = 1'b1;
        file_next = fval | (8'h01 << bsel);
      end
      cabo_pkg::CABO_TSZ_OP: begin
        skip_next = !fval[bsel];
      end
      cabo_pkg::CABO_TSO_OP: begin
        skip_next = fval[bsel];
      end
      cabo_pkg::CABO_NONE: begin
        skip_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Working register
  always_ff @(posedge mclk) begin
    if (rst) begin
      work_reg <= cabo_pkg::WORK_RST;
    end else begin
      work_reg <= work_next;
    end
  end

  // Status flags; bit ops and tests leave them alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_reg <= cabo_pkg::STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // Skip marker: holds through idle cycles until the next issued instruction, which is spent as a no-operation
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else if (skip_reg) begin
      skip_reg <= !insn.valid;
    end else begin
      skip_reg <= skip_next;
    end
  end

  // File registers; instruction writes win over a software write to the same cell
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < cabo_pkg::FILE_DEPTH; i++) begin
        file_reg[i] <= cabo_pkg::FILE_RST;
      end
    end else begin
      if (sw_wr) begin
        file_reg[sw_addr] <= sw_wdata;
      end
      if (file_we) begin
        file_reg[faddr] <= file_next;
      end
    end
  end

  // Software read data, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (sw_rd) begin
      rdata_reg <= file_reg[sw_addr];
    end
  end

  // Outputs come straight from flip-flops; exec_out alone is combinational
  assign sw_rdata = rdata_reg;
  assign work_out = work_reg;
  assign status_out = status_reg;
  assign skip_out = skip_reg;
  assign exec_out = live;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Each check looks one edge after the instruction is taken; file-cell checks
  // leave out cycles with a software write so the expected cell value stays simple

  a_add_lit_result: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_ADD_LIT_OP |=> work_reg == 8'($past(work_reg) + $past(lit)))
    else $error("add literal result wrong");

  a_add_work_dest: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_ADD_FILE_OP && !dest_file) |=> work_reg == $past(sum_file[7:0]))
    else $error("add file to work wrong");

  a_add_file_dest: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_ADD_FILE_OP && dest_file && !sw_wr) |=>
      file_reg[$past(faddr)] == 8'($past(work_reg) + $past(fval)) && work_reg == $past(work_reg))
    else $error("add file destination wrong");

  a_and_lit_flags: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_AND_LIT_OP |=> status_reg.c == $past(status_reg.c)
      && status_reg.digit_carry_flag == $past(status_reg.digit_carry_flag))
    else $error("and literal touched carry");

  a_and_file_zero: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_AND_FILE_OP |=> status_reg.z == (($past(work_reg) & $past(fval)) == 8'h00))
    else $error("and file zero flag wrong");

  a_bitop_flags: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_CLR_OP || op == cabo_pkg::CABO_SET_OP) |=> $stable(status_reg))
    else $error("bit op changed flags");

  a_clear_bit: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_CLR_OP && !sw_wr) |=> !file_reg[$past(faddr)][$past(bsel)])
    else $error("bit clear failed");

  a_set_bit: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_SET_OP && !sw_wr) |=> file_reg[$past(faddr)][$past(bsel)])
    else $error("bit set failed");

  a_tsz_skip: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_TSZ_OP |=> skip_reg == !$past(fval[bsel]))
    else $error("skip if zero wrong");

  a_tso_skip: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_TSO_OP |=> skip_reg == $past(fval[bsel]))
    else $error("skip if one wrong");

  a_skip_nop: assert property (@(posedge mclk) disable iff (rst)
    (skip_reg && insn.valid) |=> $stable(work_reg) && $stable(status_reg) && !skip_reg)
    else $error("skipped slot not a no-operation");

  a_add_carry: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_ADD_LIT_OP |=> status_reg.c == (9'($past(work_reg)) + 9'($past(lit)) > 9'h0ff)
      && status_reg.z == (work_reg == 8'h00))
    else $error("add carry or zero wrong");

  // Digit carry, AND results, neighbour bits, quiet tests and held skip: a wrong mask or nibble tap would slip past the checks above

  a_add_digit: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_ADD_FILE_OP |=> status_reg.digit_carry_flag ==
      (({1'b0, $past(work_reg[3:0])} + {1'b0, $past(fval[3:0])}) > 5'h0f))
    else $error("add file digit carry wrong");

  a_lit_digit: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_ADD_LIT_OP |=> status_reg.digit_carry_flag ==
      (({1'b0, $past(work_reg[3:0])} + {1'b0, $past(lit[3:0])}) > 5'h0f))
    else $error("add literal digit carry wrong");

  a_and_lit_result: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_AND_LIT_OP |=> work_reg == ($past(work_reg) & $past(lit)))
    else $error("and literal result wrong");

  a_and_work_dest: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_AND_FILE_OP && !dest_file) |=> work_reg == ($past(work_reg) & $past(fval)))
    else $error("and file to work wrong");

  a_and_file_dest: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_AND_FILE_OP && dest_file && !sw_wr) |=>
      file_reg[$past(faddr)] == ($past(work_reg) & $past(fval)) && $stable(work_reg))
    else $error("and file destination wrong");

  a_and_file_flags: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_AND_FILE_OP |=> status_reg.c == $past(status_reg.c)
      && status_reg.digit_carry_flag == $past(status_reg.digit_carry_flag))
    else $error("and file touched carry");

  a_and_zero: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_AND_LIT_OP |=> status_reg.z == (work_reg == 8'h00))
    else $error("and literal zero flag wrong");

  a_file_zero: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_ADD_FILE_OP && !dest_file) |=> status_reg.z == (work_reg == 8'h00))
    else $error("add file zero flag wrong");

  a_clear_keep: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_CLR_OP && !sw_wr) |=>
      (file_reg[$past(faddr)] | (8'h01 << $past(bsel))) == ($past(fval) | (8'h01 << $past(bsel))))
    else $error("bit clear touched neighbours");

  a_set_keep: assert property (@(posedge mclk) disable iff (rst)
    (op == cabo_pkg::CABO_SET_OP && !sw_wr) |=>
      (file_reg[$past(faddr)] & ~(8'h01 << $past(bsel))) == ($past(fval) & ~(8'h01 << $past(bsel))))
    else $error("bit set touched neighbours");

  a_tsz_quiet: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_TSZ_OP |=> $stable(status_reg) && $stable(work_reg))
    else $error("skip if zero changed state");

  a_tso_quiet: assert property (@(posedge mclk) disable iff (rst)
    op == cabo_pkg::CABO_TSO_OP |=> $stable(status_reg) && $stable(work_reg))
    else $error("skip if one changed state");

  a_skip_wait: assert property (@(posedge mclk) disable iff (rst)
    (skip_reg && !insn.valid) |=> skip_reg)
    else $error("pending discard lost in idle slot");
endmodule

/* File: verif/test_core_add_and_bit_ops.sv */
// Self-checking testbench for the add, AND and bit-operation execution block
`timescale 1ns/1ps
module test_core_add_and_bit_ops;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  cabo_pkg::cabo_insn_t insn = '0;
  logic [6:0] sw_addr = 7'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic [7:0] work_out;
  cabo_pkg::cabo_status_t status_out;
  logic skip_out;
  logic exec_out;
  int error_cnt = 0;
  int comparisons = 0;
  // Expected working register and flags {z, digit carry, carry}
  logic [7:0] w = 8'h00;
  logic [2:0] st = 3'h0;
  logic [7:0] fv;
  logic [7:0] fe;
  logic [7:0] lits [4] = '{8'hff, 8'h01, 8'h0f, 8'hf1};
  logic [13:0] tw [4] = '{14'h1890, 14'h1810, 14'h1c90, 14'h1c10};
  logic ts [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #5 mclk = ~mclk;

  cabo_core dut (
    .mclk(mclk), .rst(rst), .insn(insn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .work_out(work_out),
    .status_out(status_out), .skip_out(skip_out), .exec_out(exec_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Checked mid-cycle so the edge's register updates have landed
  task automatic chk_state;
    @(negedge mclk);
    chk("work", work_out, w);
    chk("status", {5'h00, status_out}, {5'h00, st});
    chk("skip", {7'h00, skip_out}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Instruction and software port drivers
  // Valid stays up so a second call issues back to back
  task automatic ex(input logic [13:0] word);
    @(posedge mclk);
    insn <= {1'b1, word};
  endtask

  task automatic idle;
    @(posedge mclk);
    insn <= '0;
  endtask

  task automatic ex1(input logic [13:0] word);
    ex(word);
    idle();
  endtask

  task automatic sw_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    @(negedge mclk);
    d = sw_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference arithmetic
  task automatic add_m(input logic [7:0] a, input logic [7:0] b, output logic [7:0] r);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    r = s[7:0];
    st = {s[7:0] == 8'h00, ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]};
  endtask

  // Byte operation on a file cell of known content, either destination
  task automatic byte_op(input logic [13:0] op, input logic [6:0] f, input logic d, input logic is_add,
                         input logic [7:0] fval);
    logic [7:0] r;
    if (is_add) begin
      add_m(w, fval, r);
    end else begin
      r = w & fval;
      st[2] = (r == 8'h00);
    end
    ex1(op | {6'h00, d, f});
    if (d) begin
      sw_read(f, fv);
      chk("file", fv, r);
    end else begin
      w = r;
    end
    chk_state();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    chk_state();
    sw_read(7'h7f, fv);
    chk("file reset", fv, 8'h00);
    // Literal adds through nibble and byte carries and a zero sum
    foreach (lits[i]) begin
      add_m(w, lits[i], w);
      ex1(14'h3e00 | {6'h00, lits[i]});
      chk_state();
    end
    // File adds and ANDs, top and bottom address, both destinations
    sw_write(7'h7f, 8'hc3);
    byte_op(14'h0700, 7'h7f, 1'b0, 1'b1, 8'hc3);
    byte_op(14'h0700, 7'h7f, 1'b1, 1'b1, 8'hc3);
    sw_write(7'h00, 8'h81);
    byte_op(14'h0500, 7'h00, 1'b1, 1'b0, 8'h81);
    byte_op(14'h0500, 7'h00, 1'b0, 1'b0, 8'h81);
    // Literal ANDs keep carry and digit carry
    w = w & 8'h8f;
    st[2] = 1'b0;
    ex1(14'h398f);
    chk_state();
    w = 8'h00;
    st[2] = 1'b1;
    ex1(14'h3970);
    chk_state();
    // Clear then set every bit position, neighbours untouched
    sw_write(7'h40, 8'h5a);
    fe = 8'h5a;
    for (int b = 0; b < 8; b++) begin
      ex1(14'h1000 | {4'h0, b[2:0], 7'h40});
      fe = fe & ~(8'h01 << b);
      sw_read(7'h40, fv);
      chk("clear bit", fv, fe);
      ex1(14'h1400 | {4'h0, b[2:0], 7'h40});
      fe = fe | (8'h01 << b);
      sw_read(7'h40, fv);
      chk("set bit", fv, fe);
    end
    chk_state();
    // Both tests on a set and a clear bit, follower issued back to back
    sw_write(7'h10, 8'h02);
    for (int i = 0; i < 4; i++) begin
      ex(tw[i]);
      ex(14'h3e01);
      @(negedge mclk);
      chk("skip", {7'h00, skip_out}, {7'h00, ts[i]});
      chk("exec", {7'h00, exec_out}, {7'h00, ~ts[i]});
      idle();
      if (!ts[i])
        add_m(w, 8'h01, w);
      chk_state();
    end
    // A pending discard survives idle cycles until the next instruction
    ex1(14'h1810);
    idle();
    @(negedge mclk);
    chk("skip held", {7'h00, skip_out}, 8'h01);
    ex1(14'h3e01);
    chk_state();
    give_verdict();
  end

  // Guard against a hung run
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule
